// [verilog/ars_supervisor.sv]
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
// Contract
// - Mode 0 does nothing; mode 1 acknowledges faults but never restarts.
// - Mode 4 restarts only after line supply failure, no further attempts.
// - Mode 6 restarts after any fault, repeating while attempts remain.
// - Mode 14 restarts after line failure only after manual acknowledge.
// - Mode 16 restarts after a fault only after manual acknowledge.
// - Mode 26 acknowledges all faults and restarts while ON is present; the code acknowledges none while the exhausted fault is up.
// - Restart mode resets to 0.
// - Start attempt limit resets to 3.
// - Limit and monitoring time act only in modes 4, 6, 14, 16, 26.
// - Each successful fault acknowledge decrements the attempt counter.
// - Limit n gives at most n+1 attempts, then exhausted fault.
// - Counter reloads when counter-reset time expires after a success.
// - Exhausted cleared by ON removed plus acknowledge; counter reloads.
// - A write changing limit or mode reloads the attempt counter.
// - Attempt wait time resets to 1 s.
// - Attempt wait time acts only in modes 4, 6 and 26.
// - Each automatic switch-on waits the configured wait time first.
// - Restart monitoring time resets to 60 s.
// - Monitoring timer starts at fault detection, stops at success.
// - Monitoring timeout without successful start raises exhausted fault.
// - Over limit+1 successes within counter-reset window raise exhausted.
// - Monitoring time zero disables monitoring.
// - Listed faults never restart; list acts in modes 6, 16, 26 only.
// - DC-link undervoltage or supply switch-off count as line failure.
module ars_supervisor #(
    parameter int TICK_CYCLES = ars_pkg::TICK_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire ars_pkg::ars_drive_s drive_i,
    input wire logic on_cmd_i,
    input wire logic manual_ack_i,
    output logic auto_ack_o,
    output logic switch_on_o,
    output logic restart_exhausted_fault_o
);

    localparam int TCW = $clog2(TICK_CYCLES);
    localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
    localparam int MW = ars_pkg::MODE_W;
    localparam int LW = ars_pkg::LIM_W;

    // Modes in which the limit and the monitoring times act.
    function automatic logic is_active(input logic [MW-1:0] m);
        return m == ars_pkg::MODE_LINE || m == ars_pkg::MODE_FAULT ||
            m == ars_pkg::MODE_LINE_MAN || m == ars_pkg::MODE_FAULT_MAN ||
            m == ars_pkg::MODE_ON_CMD;
    endfunction : is_active

    // Modes that restart only after a line supply failure.
    function automatic logic is_line(input logic [MW-1:0] m);
        return m == ars_pkg::MODE_LINE || m == ars_pkg::MODE_LINE_MAN;
    endfunction : is_line

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave.

    logic [ars_pkg::ADDR_W-1:0] addr_q;
    logic wr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_word;
    logic addr_ph;
    logic [MW-1:0] mode_q;
    logic [LW-1:0] lim_q;
    logic [ars_pkg::WAIT_W-1:0] wait_s_q;
    logic [ars_pkg::MON_W-1:0] mon_s_q;
    logic [ars_pkg::MON_W-1:0] crm_s_q;
    logic [ars_pkg::FNUM_W-1:0] sup_q [ars_pkg::SUP_N];
    logic [ars_pkg::ADDR_W-1:0] rd_addr;
    logic wr_mode;
    logic wr_lim;
    logic cfg_chg;
    logic [31:0] stat_word;

    assign addr_ph = hsel_i & htrans_i[1] & hready_i;
    assign rd_addr = haddr_i[ars_pkg::ADDR_W-1:0];
    assign wr_mode = wr_q && addr_q == ars_pkg::OFF_MODE;
    assign wr_lim = wr_q && addr_q == ars_pkg::OFF_LIMIT;
    // Only a write that really changes a value reloads the counter.
    assign cfg_chg = (wr_mode && hwdata_i[MW-1:0] != mode_q) ||
        (wr_lim && hwdata_i[LW-1:0] != lim_q);
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;

    // Read data is latched at the address phase so it comes from a flop.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_addr)
            ars_pkg::OFF_MODE: rd_word[MW-1:0] = mode_q;
            ars_pkg::OFF_LIMIT: rd_word[LW-1:0] = lim_q;
            ars_pkg::OFF_WAIT: rd_word[ars_pkg::WAIT_W-1:0] = wait_s_q;
            ars_pkg::OFF_MON: rd_word[ars_pkg::MON_W-1:0] = mon_s_q;
            ars_pkg::OFF_CRM: rd_word[ars_pkg::MON_W-1:0] = crm_s_q;
            ars_pkg::OFF_STAT: rd_word = stat_word;
            default: begin
                for (int i = 0; i < ars_pkg::SUP_N; i++) begin
                    if (rd_addr == ars_pkg::OFF_SUP + 12'(4 * i)) begin
                        rd_word[ars_pkg::FNUM_W-1:0] = sup_q[i];
                    end
                end
            end
        endcase
    end

    // Bus phase tracking; zero wait states, so no stall is ever shown.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            addr_q <= 12'h000;
            wr_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else begin
            addr_q <= rd_addr;
            wr_q <= addr_ph & hwrite_i;
            hrdata_q <= (addr_ph & ~hwrite_i) ? rd_word : hrdata_q;
        end
    end

    // Configuration registers; reset values per the factory settings.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mode_q <= ars_pkg::MODE_RST;
            lim_q <= ars_pkg::LIM_RST;
            wait_s_q <= ars_pkg::WAIT_RST_S;
            mon_s_q <= ars_pkg::MON_RST_S;
            crm_s_q <= ars_pkg::CRM_RST_S;
        end else if (wr_q) begin
            case (addr_q)
                ars_pkg::OFF_MODE: mode_q <= hwdata_i[MW-1:0];
                ars_pkg::OFF_LIMIT: lim_q <= hwdata_i[LW-1:0];
                ars_pkg::OFF_WAIT: wait_s_q <= hwdata_i[7:0];
                ars_pkg::OFF_MON: mon_s_q <= hwdata_i[15:0];
                ars_pkg::OFF_CRM: crm_s_q <= hwdata_i[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Suppression list, one entry per word.

    logic [ars_pkg::SUP_N-1:0] sup_hit;

    for (genvar g = 0; g < ars_pkg::SUP_N; g++) begin : g_sup
        localparam logic [ars_pkg::ADDR_W-1:0] OFF =
            ars_pkg::OFF_SUP + 12'(4 * g);
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                sup_q[g] <= 16'h0000;
            end else if (wr_q && addr_q == OFF) begin
                sup_q[g] <= hwdata_i[15:0];
            end
        end
        // Entry zero means empty, so a cleared list suppresses nothing.
        assign sup_hit[g] = sup_q[g] != 16'h0000 &&
            sup_q[g] == drive_i.fault_num;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event decode.

    ars_pkg::ars_state_e state_q;
    ars_pkg::ars_state_e state_d;
    ars_pkg::ars_state_e attempt_tgt;
    logic fault_prev_q;
    logic fault_rise;
    logic line_fail;
    logic active;
    logic manual;
    logic uses_wait;
    logic suppressed;
    logic eligible;
    logic fault_ev;
    logic take_attempt;
    logic cnt_zero;
    logic [LW-1:0] cnt_q;
    logic [LW-1:0] reload_val;
    logic last_q;
    logic [LW-1:0] succ_q;
    logic success;
    logic succ_over;
    logic exh_clr;
    logic reload;
    logic [ars_pkg::WAIT_W-1:0] wait_q;
    logic wait_done;
    logic [ars_pkg::MON_W-1:0] mon_cnt_q;
    logic mon_run_q;
    logic mon_exp;
    logic [ars_pkg::MON_W-1:0] crm_cnt_q;
    logic crm_run_q;
    logic crm_exp;
    logic [TCW-1:0] tick_cnt_q;
    logic tick;
    logic tick_clr;
    logic auto_ack_q;

    assign fault_rise = drive_i.fault & ~fault_prev_q;
    assign line_fail = drive_i.dc_uv | drive_i.supply_off;
    assign active = is_active(mode_q);
    assign manual = mode_q == ars_pkg::MODE_LINE_MAN ||
        mode_q == ars_pkg::MODE_FAULT_MAN;
    assign uses_wait = mode_q == ars_pkg::MODE_LINE ||
        mode_q == ars_pkg::MODE_FAULT || mode_q == ars_pkg::MODE_ON_CMD;
    assign suppressed = (|sup_hit) && (mode_q == ars_pkg::MODE_FAULT ||
        mode_q == ars_pkg::MODE_FAULT_MAN ||
        mode_q == ars_pkg::MODE_ON_CMD);
    // Line-only modes ignore every other fault, which also stops retries.
    assign eligible = active && !suppressed &&
        (!is_line(mode_q) || line_fail);
    assign fault_ev = fault_rise && active && state_q != ars_pkg::ST_EXH;
    assign take_attempt = (fault_ev && eligible && !manual) ||
        (state_q == ars_pkg::ST_ACK && manual_ack_i);
    assign cnt_zero = cnt_q == 8'h00;
    assign attempt_tgt = (cnt_zero && last_q) ? ars_pkg::ST_EXH :
        (uses_wait ? ars_pkg::ST_WAIT : ars_pkg::ST_START);
    assign success = state_q == ars_pkg::ST_START && drive_i.start_ok;
    assign succ_over = success && crm_s_q != 16'h0000 &&
        succ_q > lim_q;
    assign exh_clr = state_q == ars_pkg::ST_EXH && !on_cmd_i &&
        manual_ack_i;
    assign reload = cfg_chg || crm_exp || exh_clr;
    // A limit write reloads the value being written, not the old one.
    assign reload_val = wr_lim ? hwdata_i[LW-1:0] : lim_q;
    assign wait_done = wait_q == 8'h00;
    assign mon_exp = mon_run_q && mon_cnt_q == 16'h0000 && tick;
    assign crm_exp = crm_run_q && crm_cnt_q == 16'h0000 &&
        (tick || crm_s_q == 16'h0000);
    assign tick = tick_cnt_q == TICK_LAST;
    // The tick is restarted on entry to the wait so it lasts whole seconds.
    assign tick_clr = state_d == ars_pkg::ST_WAIT &&
        (state_q != ars_pkg::ST_WAIT || take_attempt);
    assign switch_on_o = state_q == ars_pkg::ST_START;
    assign restart_exhausted_fault_o = state_q == ars_pkg::ST_EXH;
    assign auto_ack_o = auto_ack_q;
    assign stat_word = {succ_q, 6'h00, switch_on_o,
        restart_exhausted_fault_o, 5'h00, state_q, cnt_q};

    ////////////////////////////////////////////////////////////////////////
    // Restart sequencing.

    always_comb begin
        state_d = state_q;
        case (state_q)
            ars_pkg::ST_IDLE, ars_pkg::ST_WAIT, ars_pkg::ST_START: begin
                if (take_attempt) begin
                    state_d = attempt_tgt;
                end else if (fault_ev && eligible) begin
                    state_d = ars_pkg::ST_ACK;
                end else if (fault_ev) begin
                    state_d = ars_pkg::ST_IDLE;
                end else if (succ_over || mon_exp) begin
                    state_d = ars_pkg::ST_EXH;
                end else if (success) begin
                    state_d = ars_pkg::ST_IDLE;
                end else if (state_q == ars_pkg::ST_WAIT && wait_done &&
                        (mode_q != ars_pkg::MODE_ON_CMD || on_cmd_i)) begin
                    state_d = ars_pkg::ST_START;
                end
            end
            ars_pkg::ST_ACK: begin
                if (take_attempt) begin
                    state_d = attempt_tgt;
                end else if (mon_exp) begin
                    state_d = ars_pkg::ST_EXH;
                end
            end
            ars_pkg::ST_EXH: begin
                if (exh_clr) begin
                    state_d = ars_pkg::ST_IDLE;
                end
            end
            default: state_d = ars_pkg::ST_IDLE;
        endcase
        // Modes 0 and 1 never hold a restart in progress.
        if (!active && state_q != ars_pkg::ST_EXH) begin
            state_d = ars_pkg::ST_IDLE;
        end
    end

    // State, fault edge and acknowledge pulse.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= ars_pkg::ST_IDLE;
            fault_prev_q <= 1'b0;
            auto_ack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            fault_prev_q <= drive_i.fault;
            auto_ack_q <= fault_rise && state_q != ars_pkg::ST_EXH &&
                (mode_q == ars_pkg::MODE_ACK ||
                mode_q == ars_pkg::MODE_ON_CMD ||
                (eligible && !manual));
        end
    end

    // Attempt counter and success count within the reset window.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_q <= ars_pkg::LIM_RST;
            last_q <= 1'b0;
            succ_q <= 8'h00;
        end else begin
            if (reload) begin
                cnt_q <= reload_val;
                last_q <= 1'b0;
            end else if (take_attempt && !cnt_zero) begin
                cnt_q <= cnt_q - 8'h01;
            end else if (take_attempt) begin
                // A zero count still grants the last of n+1 attempts.
                last_q <= 1'b1;
            end
            if (crm_exp || exh_clr) begin
                succ_q <= 8'h00;
            end else if (success) begin
                succ_q <= succ_q + 8'h01;
            end
        end
    end

    // One-second tick and the attempt wait-time countdown.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
            wait_q <= 8'h00;
        end else begin
            tick_cnt_q <= (tick || tick_clr) ? '0 : tick_cnt_q + 1'b1;
            if (tick_clr) begin
                wait_q <= wait_s_q;
            end else if (tick && !wait_done) begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end

    // Monitor runs from fault detection to success; zero turns it off.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mon_run_q <= 1'b0;
            mon_cnt_q <= 16'h0000;
        end else if (fault_ev && !mon_run_q && mon_s_q != 16'h0000) begin
            mon_run_q <= 1'b1;
            mon_cnt_q <= mon_s_q;
        end else if (success || state_d == ars_pkg::ST_IDLE ||
                state_d == ars_pkg::ST_EXH) begin
            mon_run_q <= 1'b0;
        end else if (tick && mon_cnt_q != 16'h0000) begin
            mon_cnt_q <= mon_cnt_q - 16'h0001;
        end
    end

    // The counter-reset window opens at each success that starts none.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            crm_run_q <= 1'b0;
            crm_cnt_q <= 16'h0000;
        end else if (success && !crm_run_q) begin
            crm_run_q <= 1'b1;
            crm_cnt_q <= crm_s_q;
        end else if (crm_exp) begin
            crm_run_q <= 1'b0;
        end else if (tick && crm_cnt_q != 16'h0000) begin
            crm_cnt_q <= crm_cnt_q - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    mode_off_a: assert property (mode_q == ars_pkg::MODE_OFF &&
        $past(mode_q) == ars_pkg::MODE_OFF |-> !auto_ack_o && !switch_on_o)
        else $error("Mode 0 acted on its own.");
    ack_only_a: assert property (mode_q == ars_pkg::MODE_ACK &&
        $past(mode_q) == ars_pkg::MODE_ACK |-> !switch_on_o)
        else $error("Mode 1 switched the motor on.");
    line_only_a: assert property (mode_q == ars_pkg::MODE_LINE &&
        take_attempt |-> line_fail)
        else $error("Mode 4 attempted without line failure.");
    attempt_dec_a: assert property (take_attempt && !cnt_zero &&
        !reload |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("Attempt counter not decremented.");
    limit_exh_a: assert property (take_attempt && cnt_zero && last_q |=>
        restart_exhausted_fault_o)
        else $error("Attempts beyond limit without exhausted fault.");
    cfg_reload_a: assert property (cfg_chg |=> cnt_q == lim_q)
        else $error("Changed setting did not reload counter.");
    exh_clear_a: assert property (exh_clr |=>
        !restart_exhausted_fault_o && cnt_q == $past(lim_q))
        else $error("Exhausted fault not cleared and reloaded.");
    mon_exp_a: assert property (mon_exp && !success |=>
        restart_exhausted_fault_o)
        else $error("Monitor expiry did not raise exhausted fault.");
    mon_off_a: assert property (!mon_run_q && mon_s_q == 16'h0000
        |=> !mon_run_q)
        else $error("Monitor started while disabled.");
    wait_first_a: assert property ($rose(switch_on_o) &&
        $past(state_q) == ars_pkg::ST_WAIT |-> $past(wait_q) == 8'h00)
        else $error("Switch-on before wait time elapsed.");

    restart_c: cover property (state_q == ars_pkg::ST_WAIT ##1
        switch_on_o ##[1:16] success);
    manual_c: cover property (state_q == ars_pkg::ST_ACK ##1 switch_on_o);
    exhaust_c: cover property (exh_clr);

endmodule : ars_supervisor

// [verilog/ars_pkg.sv]
package ars_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 25;
    localparam int SEC_NS = 1_000_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = TICK_S * (SEC_NS / CLK_PERIOD_NS);

    // Field widths.
    localparam int MODE_W = 5;
    localparam int LIM_W = 8;
    localparam int WAIT_W = 8;
    localparam int MON_W = 16;
    localparam int FNUM_W = 16;
    localparam int SUP_N = 10;

    // Values after reset, times in seconds.
    localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
    localparam logic [LIM_W-1:0] LIM_RST = 8'h03;
    localparam logic [WAIT_W-1:0] WAIT_RST_S = 8'h01;
    localparam logic [MON_W-1:0] MON_RST_S = 16'h003c;
    localparam logic [MON_W-1:0] CRM_RST_S = 16'h0000;

    // Restart mode codes.
    localparam logic [MODE_W-1:0] MODE_OFF = 5'h00;
    localparam logic [MODE_W-1:0] MODE_ACK = 5'h01;
    localparam logic [MODE_W-1:0] MODE_LINE = 5'h04;
    localparam logic [MODE_W-1:0] MODE_FAULT = 5'h06;
    localparam logic [MODE_W-1:0] MODE_LINE_MAN = 5'h0e;
    localparam logic [MODE_W-1:0] MODE_FAULT_MAN = 5'h10;
    localparam logic [MODE_W-1:0] MODE_ON_CMD = 5'h1a;

    // Register byte offsets.
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_MODE = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_LIMIT = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_WAIT = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_MON = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_CRM = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_STAT = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_SUP = 12'h040;

    // Status word field positions.
    localparam int ST_CNT_LSB = 0;
    localparam int ST_STATE_LSB = 8;
    localparam int ST_EXH_BIT = 16;
    localparam int ST_SWON_BIT = 17;
    localparam int ST_SUCC_LSB = 24;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ACK, ST_WAIT, ST_START, ST_EXH
    } ars_state_e;

    // Signals from the drive's fault logic and switch-on sequencer.
    typedef struct packed {
        logic fault;
        logic [FNUM_W-1:0] fault_num;
        logic dc_uv;
        logic supply_off;
        logic start_ok;
    } ars_drive_s;

endpackage : ars_pkg

// [dv/ars_drive_model.sv]
`timescale 1ns/10ps
// Far side of the supervisor: drive fault logic and switch-on sequencer.
module ars_drive_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic fault_req_i,
    input wire logic [15:0] fault_num_i,
    input wire logic line_i,
    input wire logic ok_en_i,
    input wire logic [3:0] ok_dly_i,
    input wire logic switch_on_i,
    output ars_pkg::ars_drive_s drive_o
);
    logic [2:0] hold_q;
    logic [3:0] dly_q;
    logic [15:0] num_q;
    logic ok_q;
    wire logic up = hold_q != 3'h0;
    ////////////////////////////////////////////////////////////////////////
    // A fault stays up four cycles, so each request gives one clean rise.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hold_q <= 3'h0;
            num_q <= 16'h0000;
        end else if (fault_req_i) begin
            hold_q <= 3'h4;
            num_q <= fault_num_i;
        end else if (up) begin
            hold_q <= hold_q - 3'h1;
        end
    end
    // The start succeeds ok_dly_i+1 cycles into a switch-on, prompt or slow.
    always_ff @(posedge mclk_i) begin
        dly_q <= (switch_on_i && ok_en_i) ? dly_q + 4'h1 : 4'h0;
        ok_q <= switch_on_i && ok_en_i && dly_q == ok_dly_i;
    end
    // Released number lines show the inverse, so a stale read is caught.
    // An even number reports undervoltage, an odd one a supply switch-off.
    assign drive_o = '{fault: up, fault_num: up ? num_q : ~num_q,
        dc_uv: up && line_i && !num_q[0],
        supply_off: up && line_i && num_q[0],
        start_ok: ok_q};
endmodule : ars_drive_model

// [dv/auto_restart_supervisor_test.sv]
`timescale 1ns/10ps
module auto_restart_supervisor_test;
    localparam int T = 10;
    logic mclk_i, rst_i, hsel, hwrite, hready, hresp, on_cmd, man_ack;
    logic auto_ack, sw_on, exh, f_req, line, ok_en, ex;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] f_num;
    logic [3:0] ok_dly;
    ars_pkg::ars_drive_s drv;
    int bad_count, samples_checked, acks, on_at;
    ars_supervisor #(.TICK_CYCLES(T)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .drive_i(drv), .on_cmd_i(on_cmd),
        .manual_ack_i(man_ack), .auto_ack_o(auto_ack),
        .switch_on_o(sw_on), .restart_exhausted_fault_o(exh));
    ars_drive_model model (.mclk_i(mclk_i), .rst_i(rst_i),
        .fault_req_i(f_req), .fault_num_i(f_num), .line_i(line),
        .ok_en_i(ok_en), .ok_dly_i(ok_dly), .switch_on_i(sw_on),
        .drive_o(drv));
    ////////////////////////////////////////////////////////////////////////
    // One AHB single transfer; a write ignores q, a read ignores d.
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk_i); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic chk(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Raises one fault through the model; line selects a supply failure.
    task automatic fault(input logic [15:0] n, input logic l);
        @(posedge mclk_i);
        f_req <= 1'b1;
        f_num <= n;
        line <= l;
        @(posedge mclk_i);
        f_req <= 1'b0;
    endtask : fault
    task automatic pulse_ack;
        @(posedge mclk_i);
        man_ack <= 1'b1;
        @(posedge mclk_i);
        man_ack <= 1'b0;
    endtask : pulse_ack
    // Watches n settled cycles: acknowledges, first switch-on, exhaustion.
    task automatic run(input int n);
        acks = 0;
        on_at = 0;
        ex = 1'b0;
        for (int i = 1; i <= n; i++) begin
            @(posedge mclk_i);
            #1;
            if (auto_ack === 1'b1) acks++;
            if (sw_on === 1'b1 && on_at == 0) on_at = i;
            if (exh === 1'b1) ex = 1'b1;
        end
    endtask : run
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (6000) @(posedge mclk_i);
        bad_count++;
        summarize();
    end
    initial begin
        {rst_i, hsel, hwrite, on_cmd, man_ack, f_req, line} = 7'h41;
        {ok_en, haddr, hwdata, htrans, hsize, f_num} = {33'h0, 32'h0, 5'h2,
            16'h0};
        ok_dly = 4'h0;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        bus(12'h000, 0, 0, v); chk("mode", v, 32'h0);
        bus(12'h004, 0, 0, v); chk("limit", v, 32'h3);
        bus(12'h008, 0, 0, v); chk("wait", v, 32'h1);
        bus(12'h00c, 0, 0, v); chk("mon", v, 32'h3c);
        bus(12'h100, 0, 0, v); chk("unmapped", v, 32'h0);
        chk("resp", hresp, 32'h0);
        $display("test reset done");
        ok_en <= 1'b1;
        fault(16'h5, 0); run(40); chk("m0", acks + on_at, 0);
        bus(12'h000, 1, 32'h1, v);
        fault(16'h5, 0); run(40); chk("m1ack", acks, 1);
        chk("m1on", on_at, 0);
        $display("test modes 0 and 1 done");
        ok_en <= 1'b0;
        bus(12'h000, 1, 32'h6, v);
        fault(16'h5, 0); run(40); chk("m6ack", acks, 1);
        chk("m6wait1", on_at inside {[T - 2 : 2 * T + 5]}, 1);
        bus(12'h014, 0, 0, v); chk("m6cnt", v[7:0], 32'h2);
        ok_en <= 1'b1;
        run(10); chk("m6ok", sw_on, 0);
        bus(12'h008, 1, 32'h3, v);
        fault(16'h5, 0); run(60);
        chk("m6wait3", on_at inside {[3 * T - 2 : 4 * T + 5]}, 1);
        $display("test mode 6 done");
        ok_en <= 1'b0;
        on_cmd <= 1'b1;
        bus(12'h008, 1, 32'h1, v);
        bus(12'h004, 1, 32'h1, v);
        bus(12'h014, 0, 0, v); chk("reload", v[7:0], 32'h1);
        fault(16'h5, 0); run(30); chk("try1", ex, 0);
        fault(16'h5, 0); run(30); chk("try2", ex, 0);
        fault(16'h5, 0); run(30); chk("exh", ex, 1);
        pulse_ack(); run(3); chk("exhon", exh, 1);
        on_cmd <= 1'b0;
        pulse_ack(); run(3); chk("exhclr", exh, 0);
        bus(12'h014, 0, 0, v); chk("cnt13", v[7:0], 32'h1);
        $display("test exhaustion done");
        {ok_en, ok_dly, on_cmd} <= 6'h2b;
        bus(12'h000, 1, 32'h4, v);
        fault(16'h5, 0); run(30); chk("m4plain", acks + on_at, 0);
        fault(16'h6, 1); run(30); chk("m4uv", on_at > 0, 1);
        fault(16'h7, 1); run(30); chk("m4off", on_at > 0, 1);
        $display("test mode 4 done");
        bus(12'h000, 1, 32'h10, v);
        fault(16'h8, 0); run(30); chk("m16hold", on_at, 0);
        pulse_ack(); run(5); chk("m16on", on_at > 0, 1);
        $display("test mode 16 done");
        bus(12'h000, 1, 32'h1a, v);
        on_cmd <= 1'b0;
        fault(16'h8, 0); run(30); chk("m26ack", acks, 1);
        chk("m26off", on_at, 0);
        on_cmd <= 1'b1;
        run(10); chk("m26on", on_at > 0, 1);
        $display("test mode 26 done");
        bus(12'h00c, 1, 32'h1, v);
        bus(12'h008, 1, 32'h5, v);
        bus(12'h000, 1, 32'h6, v);
        fault(16'h5, 0); run(40); chk("monexp", {on_at > 0, ex}, 1);
        $display("test monitor done");
        on_cmd <= 1'b0;
        pulse_ack();
        bus(12'h040, 1, 32'h5, v);
        bus(12'h040, 0, 0, v); chk("supval", v, 32'h5);
        fault(16'h5, 0); run(30); chk("sup", acks + on_at, 0);
        $display("test suppress done");
        summarize();
    end
endmodule : auto_restart_supervisor_test
